// ===== verilog/irs_top.sv
// Interrupt routing status: raw view, cause views and output gates
// How it works
// - Raw view register shows live, unlatched, active-high source levels.
// - Pin input bit 0 is polarity corrected before the raw view.
// - Management sources at bits 28 and 27, check_source_a check at 25.
// - Inject ready sources at 21,20; extract ready at 17,16.
// - Analyzer 15, port aggregate 14, serial pin 13, pin 12, two-wire 11.
// - Timers at 9, 8, 7; serial port at 6.
// - Software sources at 3 and 2, pin input at 0; rest zero.
// - Per processor line, a read-only cause register of contributing sources.
// - Bit-0 gates for both lines and pin output, reset zero.
// - Two-bit selector routes each source: 0 line A, 1 line B, 2 pin.
// - Per-source enable, reset zero, gates propagation.
// - Pin polarity corrected at the edge; everything inside is active high.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "irs_consts.svh"
module irs_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic [31:0] src_in,
    input wire logic external_pin_interrupt,
    output logic processor_line_a,
    output logic processor_line_b,
    output logic pin_line_out,
    output logic pin_line_oe,
    output logic event_irq
);
    irs_pkg::irs_req_s req;
    irs_pkg::irs_lines_s lines;
    logic [31:0] src_sync;
    logic [31:0] src_level_view;
    logic [31:0] cause_a, cause_b, cause_p;
    logic gate_a_q, gate_b_q, gate_p_q;
    logic external_pin_polarity_q;
    logic [31:0] per_source_enable_q;
    logic [63:0] destination_select_q;
    logic [2:0] stat_q, mask_q;
    logic [2:0] lines_vec, lines_prev_q, ev_rise;
    logic [31:0] rdata_q;

    assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

    // Pin sources come from other domains
    irs_sync #(.W(32)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .din({src_in[31:1], external_pin_interrupt}),
        .dout(src_sync)
    );

    always_comb
    begin
        src_level_view = src_sync
            & `IRS_SRC_MASK;
        // Pin active low when polarity is zero
        src_level_view[`IRS_BIT_PIN] =
            src_sync[`IRS_BIT_PIN] ~^ external_pin_polarity_q;
    end

    irs_route u_route (
        .pend(src_level_view),
        .src_en(per_source_enable_q),
        .sel(destination_select_q),
        .cause_a(cause_a),
        .cause_b(cause_b),
        .cause_p(cause_p)
    );

    // Gated outputs
    assign lines.line_a = gate_a_q & (|cause_a);
    assign lines.line_b = gate_b_q & (|cause_b);
    assign lines.pin = gate_p_q & (|cause_p);
    assign processor_line_a = lines.line_a;
    assign processor_line_b = lines.line_b;
    // Pin drives at configured polarity, only while active
    assign pin_line_out = ~(lines.pin ^ external_pin_polarity_q);
    assign pin_line_oe = lines.pin;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            gate_a_q <= 1'b0;
            gate_b_q <= 1'b0;
            gate_p_q <= 1'b0;
        end
        else if (req.wr)
        begin
            case (req.addr)
                `IRS_OFS_GATE0: gate_a_q <= req.wdata[`IRS_GATE_BIT];
                `IRS_OFS_GATE1: gate_b_q <= req.wdata[`IRS_GATE_BIT];
                `IRS_OFS_PGATE: gate_p_q <= req.wdata[`IRS_GATE_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            per_source_enable_q <= `IRS_RST_WORD;
            destination_select_q <= '0;
            external_pin_polarity_q <= 1'b0;
        end
        else if (req.wr)
        begin
            case (req.addr)
                `IRS_OFS_SRCEN:
                    per_source_enable_q <= req.wdata & `IRS_SRC_MASK;
                `IRS_OFS_SELLO:
                    destination_select_q[31:0] <= req.wdata;
                `IRS_OFS_SELHI:
                    destination_select_q[63:32] <= req.wdata;
                `IRS_OFS_POL:
                    external_pin_polarity_q <= req.wdata[`IRS_BIT_PIN];
                default: ;
            endcase
        end
    end

    // Rising edges of each output line are the sticky events
    assign lines_vec = {lines.pin, lines.line_b, lines.line_a};
    assign ev_rise = lines_vec & ~lines_prev_q;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            lines_prev_q <= '0;
        else
            lines_prev_q <= lines_vec;
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge core_clk)
    begin
        if (rst)
            stat_q <= '0;
        else if (req.wr && req.addr == `IRS_OFS_STAT)
            stat_q <= (stat_q & ~req.wdata[2:0]) | ev_rise;
        else
            stat_q <= stat_q | ev_rise;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            mask_q <= '0;
        else if (req.wr && req.addr == `IRS_OFS_MASK)
            mask_q <= req.wdata[2:0];
    end

    assign event_irq = |(stat_q & mask_q);

    // Read data valid the cycle after the strobe only
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rdata_q <= '0;
        else if (req.rd)
        begin
            case (req.addr)
                `IRS_OFS_RAW: rdata_q <= src_level_view;
                `IRS_OFS_GATE0: rdata_q <= {31'h0, gate_a_q};
                `IRS_OFS_CAUSE0: rdata_q <= cause_a;
                `IRS_OFS_GATE1: rdata_q <= {31'h0, gate_b_q};
                `IRS_OFS_CAUSE1: rdata_q <= cause_b;
                `IRS_OFS_PGATE: rdata_q <= {31'h0, gate_p_q};
                `IRS_OFS_PCAUSE: rdata_q <= cause_p;
                `IRS_OFS_SRCEN: rdata_q <= per_source_enable_q;
                `IRS_OFS_SELLO: rdata_q <= destination_select_q[31:0];
                `IRS_OFS_SELHI: rdata_q <= destination_select_q[63:32];
                `IRS_OFS_POL: rdata_q <= {31'h0, external_pin_polarity_q};
                `IRS_OFS_STAT: rdata_q <= {29'h0, stat_q};
                `IRS_OFS_MASK: rdata_q <= {29'h0, mask_q};
                default: rdata_q <= '0;
            endcase
        end
        else
            rdata_q <= '0;
    end
    assign rdata = rdata_q;

    // Gates: a cleared gate must silence its line whatever the causes
    line_a_gate_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !gate_a_q |-> !processor_line_a)
        else $error("line A high while gate off");

    line_b_gate_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !gate_b_q |-> !processor_line_b)
        else $error("line B high while gate off");

    pin_gate_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !gate_p_q |-> !pin_line_oe)
        else $error("pin driven while gate off");

    gate_reset_a: assert property (
        @(posedge core_clk) disable iff (rst)
        $past(rst) |-> !gate_a_q && !gate_b_q && !gate_p_q)
        else $error("gate not cleared by reset");

    gate_read_a: assert property (
        @(posedge core_clk) disable iff (rst)
        rd_stb && addr == `IRS_OFS_GATE0
            |=> rdata == {31'h0, $past(gate_a_q)})
        else $error("gate read wrong");

    // Lines are combinational, so they follow the cause in the same cycle
    line_a_cause_a: assert property (
        @(posedge core_clk) disable iff (rst)
        processor_line_a == (gate_a_q && cause_a != 0))
        else $error("line A disagrees with cause");

    line_b_cause_a: assert property (
        @(posedge core_clk) disable iff (rst)
        processor_line_b == (gate_b_q && cause_b != 0))
        else $error("line B disagrees with cause");

    pin_cause_a: assert property (
        @(posedge core_clk) disable iff (rst)
        pin_line_oe == (gate_p_q && cause_p != 0))
        else $error("pin drive disagrees with cause");

    pin_drive_a: assert property (
        @(posedge core_clk) disable iff (rst)
        pin_line_oe |-> pin_line_out == external_pin_polarity_q)
        else $error("pin driven at wrong level");

    pin_pol_a: assert property (
        @(posedge core_clk) disable iff (rst)
        src_level_view[0] == (src_sync[0] ~^ external_pin_polarity_q))
        else $error("pin polarity wrong");

    // Cause bits need a live, enabled source routed to one place only
    cause_live_a: assert property (
        @(posedge core_clk) disable iff (rst)
        ((cause_a | cause_b | cause_p) & ~src_level_view) == 0)
        else $error("cause from idle source");

    cause_enable_a: assert property (
        @(posedge core_clk) disable iff (rst)
        ((cause_a | cause_b | cause_p) & ~per_source_enable_q) == 0)
        else $error("cause from disabled source");

    srcen_reset_a: assert property (
        @(posedge core_clk) disable iff (rst)
        $past(rst) |-> per_source_enable_q == `IRS_RST_WORD)
        else $error("source enable not cleared by reset");

    srcen_rsvd_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (per_source_enable_q & ~`IRS_SRC_MASK) == 0)
        else $error("reserved enable bit set");

    cause_excl_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (cause_a & cause_b) == 0)
        else $error("source routed to two lines");

    cause_pin_excl_a: assert property (
        @(posedge core_clk) disable iff (rst)
        ((cause_a | cause_b) & cause_p) == 0)
        else $error("source routed to line and pin");

    // Read data is one cycle late, so compare against last cycle's view
    raw_rsvd_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (src_level_view & ~`IRS_SRC_MASK) == 0)
        else $error("reserved raw bit set");

    raw_live_a: assert property (
        @(posedge core_clk) disable iff (rst)
        rd_stb && addr == `IRS_OFS_RAW
            |=> rdata == $past(src_level_view))
        else $error("raw read wrong");

    cause_read_a: assert property (
        @(posedge core_clk) disable iff (rst)
        rd_stb && addr == `IRS_OFS_CAUSE0
            |=> rdata == $past(cause_a))
        else $error("cause read wrong");

    cause_b_read_a: assert property (
        @(posedge core_clk) disable iff (rst)
        rd_stb && addr == `IRS_OFS_CAUSE1
            |=> rdata == $past(cause_b))
        else $error("line B cause read wrong");

    pin_cause_read_a: assert property (
        @(posedge core_clk) disable iff (rst)
        rd_stb && addr == `IRS_OFS_PCAUSE
            |=> rdata == $past(cause_p))
        else $error("pin cause read wrong");

    srcen_read_a: assert property (
        @(posedge core_clk) disable iff (rst)
        rd_stb && addr == `IRS_OFS_SRCEN
            |=> rdata == $past(per_source_enable_q))
        else $error("source enable read wrong");

    cov_line_a: cover property (@(posedge core_clk) processor_line_a);
    cov_line_b: cover property (@(posedge core_clk) processor_line_b);
    cov_pin: cover property (@(posedge core_clk) pin_line_oe);
    cov_irq: cover property (@(posedge core_clk) event_irq);
    cov_pin_low: cover property (
        @(posedge core_clk) pin_line_oe && !pin_line_out);
endmodule // irs_top

// ===== verilog/irs_consts.svh
// Constants for the interrupt routing and status block
`ifndef IRS_CONSTS_SVH
`define IRS_CONSTS_SVH
`define IRS_ADDR_W 4
`define IRS_DATA_W 32
`define IRS_OFS_RAW 4'h0
`define IRS_OFS_GATE0 4'h1
`define IRS_OFS_CAUSE0 4'h2
`define IRS_OFS_GATE1 4'h3
`define IRS_OFS_CAUSE1 4'h4
`define IRS_OFS_PGATE 4'h5
`define IRS_OFS_PCAUSE 4'h6
`define IRS_OFS_SRCEN 4'h7
`define IRS_OFS_SELLO 4'h8
`define IRS_OFS_SELHI 4'h9
`define IRS_OFS_POL 4'hA
`define IRS_OFS_STAT 4'hB
`define IRS_OFS_MASK 4'hC
`define IRS_SRC_MASK 32'h1A33_FBCD
`define IRS_BIT_PIN 0
`define IRS_GATE_BIT 0
`define IRS_DST_LINE_A 2'h0
`define IRS_DST_LINE_B 2'h1
`define IRS_DST_PIN 2'h2
`define IRS_RST_WORD 32'h0000_0000
`define IRS_EV_A 0
`define IRS_EV_B 1
`define IRS_EV_P 2
`endif

// ===== verilog/irs_pkg.sv
// Types shared by the interrupt routing and status block
package irs_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } irs_req_s;
    typedef struct packed {
        logic line_a;
        logic line_b;
        logic pin;
    } irs_lines_s;
endpackage

// ===== verilog/irs_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module irs_sync #(
    parameter int W = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            dout <= '0;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // irs_sync

// ===== verilog/irs_route.sv
// Per-destination cause vectors from pending, enable and selector
`timescale 1ns/1ns
`include "irs_consts.svh"
module irs_route (
    input wire logic [31:0] pend,
    input wire logic [31:0] src_en,
    input wire logic [63:0] sel,
    output logic [31:0] cause_a,
    output logic [31:0] cause_b,
    output logic [31:0] cause_p
);
    function automatic logic [31:0] match(input logic [63:0] s,
                                          input logic [1:0] d);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 32; i++)
            m[i] = (s[2*i +: 2] == d);
        return m;
    endfunction
    always_comb
    begin
        // Cause bit: pending and enabled and routed here
        cause_a = pend & src_en & match(sel, `IRS_DST_LINE_A)
            & `IRS_SRC_MASK;
        cause_b = pend & src_en & match(sel, `IRS_DST_LINE_B)
            & `IRS_SRC_MASK;
        cause_p = pend & src_en & match(sel, `IRS_DST_PIN)
            & `IRS_SRC_MASK;
    end
endmodule // irs_route

// ===== tb/irs_cpu_model.sv
// Behavioural processor side counting interrupt line assertions
`timescale 1ns/1ns
module irs_cpu_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic line_a,
    input wire logic line_b,
    output logic [7:0] hits_a,
    output logic [7:0] hits_b
);
    logic prev_a_q;
    logic prev_b_q;
    // Lines are levels, so only a low-to-high step is a new request
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            prev_a_q <= 1'b0;
            prev_b_q <= 1'b0;
            hits_a <= 8'h00;
            hits_b <= 8'h00;
        end
        else
        begin
            prev_a_q <= line_a;
            prev_b_q <= line_b;
            hits_a <= hits_a + {7'h00, line_a & ~prev_a_q};
            hits_b <= hits_b + {7'h00, line_b & ~prev_b_q};
        end
    end
endmodule // irs_cpu_model

// ===== tb/irs_top_tb_top.sv
// Self-checking bench for the interrupt routing status block
`timescale 1ns/1ns
module irs_top_tb_top;
    // Live source bits with all inputs high, pin inactive
    localparam logic [31:0] LIVE = 32'h1A33_FBCC;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rdata;
    logic [31:0] src_in = 32'h0;
    logic external_pin_interrupt = 1'b1;
    logic processor_line_a;
    logic processor_line_b;
    logic pin_line_out;
    logic pin_line_oe;
    logic event_irq;
    logic [7:0] hits_a;
    logic [7:0] hits_b;
    int error_cnt = 0;
    int cmp_count = 0;

    always #20 core_clk = ~core_clk;

    irs_top u_irs_top (.core_clk(core_clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .src_in(src_in), .external_pin_interrupt(external_pin_interrupt),
        .processor_line_a(processor_line_a),
        .processor_line_b(processor_line_b), .pin_line_out(pin_line_out),
        .pin_line_oe(pin_line_oe), .event_irq(event_irq));
    irs_cpu_model u_irs_cpu_model (.core_clk(core_clk), .rst(rst),
        .line_a(processor_line_a), .line_b(processor_line_b),
        .hits_a(hits_a), .hits_b(hits_b));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    // Inputs pass a two-flop synchroniser, so allow three edges
    task automatic drive(input logic [31:0] s, input logic p);
        @(posedge core_clk);
        src_in <= s;
        external_pin_interrupt <= p;
        settle(3);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        error_cnt++;
        conclude;
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(4'h1, 32'h0);
        rd(4'h3, 32'h0);
        rd(4'h5, 32'h0);
        rd(4'h0, 32'h0);
        wr(4'h1, 32'hFFFF_FFFF);
        rd(4'h1, 32'h1);
        wr(4'h1, 32'h0);
        wr(4'h0, 32'hFFFF_FFFF);
        wr(4'h2, 32'hFFFF_FFFF);
        wr(4'hD, 32'hFFFF_FFFF);
        rd(4'hD, 32'h0);
        rd(4'h2, 32'h0);
        $display("test access done");
        drive(32'hFFFF_FFFF, 1'b1);
        rd(4'h0, LIVE);
        drive(32'hFFFF_FFFF, 1'b0);
        rd(4'h0, LIVE | 32'h1);
        wr(4'hA, 32'h1);
        settle(2);
        rd(4'h0, LIVE);
        drive(32'h0000_0004, 1'b1);
        rd(4'h0, 32'h5);
        drive(32'hFFFF_FFFF, 1'b0);
        $display("test raw done");
        wr(4'h1, 32'h1);
        wr(4'h3, 32'h1);
        wr(4'h5, 32'h1);
        wr(4'h7, 32'hFFFF_FFFF);
        for (int d = 0; d < 4; d++)
        begin
            wr(4'h8, {16{d[1:0]}});
            wr(4'h9, {16{d[1:0]}});
            settle(1);
            check(processor_line_a, d == 0);
            check(processor_line_b, d == 1);
            check(pin_line_oe, d == 2);
            if (d == 2)
                check(pin_line_out, 1'b1);
            rd(4'h2, d == 0 ? LIVE : 32'h0);
            rd(4'h4, d == 1 ? LIVE : 32'h0);
            rd(4'h6, d == 2 ? LIVE : 32'h0);
        end
        check(hits_a, 8'h01);
        check(hits_b, 8'h01);
        $display("test routing done");
        rd(4'hB, 32'h7);
        check(event_irq, 1'b0);
        wr(4'hC, 32'h7);
        settle(1);
        check(event_irq, 1'b1);
        wr(4'hB, 32'h7);
        settle(1);
        check(event_irq, 1'b0);
        rd(4'hB, 32'h0);
        $display("test events done");
        wr(4'h8, 32'h0);
        wr(4'h9, 32'h0);
        wr(4'h7, 32'h0000_0800);
        settle(1);
        rd(4'h2, 32'h0000_0800);
        check(processor_line_a, 1'b1);
        wr(4'h1, 32'h0);
        settle(1);
        check(processor_line_a, 1'b0);
        check(event_irq, 1'b1);
        check(hits_a, 8'h02);
        wr(4'h8, 32'h0080_0000);
        settle(1);
        check(pin_line_oe, 1'b1);
        rd(4'h6, 32'h0000_0800);
        wr(4'hA, 32'h0);
        settle(1);
        check(pin_line_out, 1'b0);
        check(pin_line_oe, 1'b1);
        $display("test gating done");
        conclude;
    end
endmodule // irs_top_tb_top
